// [logic/rst_wdt_pkg.sv]
// constants for the reset and watchdog controller
package rst_wdt_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned MIN_EXT_PULSE_NS  = 1000;
  localparam int unsigned MIN_EXT_CYC       =
    (MIN_EXT_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RC_OSC_HZ         = 2_000_000;
  localparam int unsigned WDT_RST_CYC       = CLK_HZ / RC_OSC_HZ;
  localparam int unsigned SW_RST_CYC        = 2;

  // release sequence stage lengths in clk cycles
  localparam int unsigned RST_DELAY_CYC     = 64;
  localparam int unsigned OSC_START_CYC     = 32;
  localparam int unsigned OSC_CAL_CYC       = 16;

  // watchdog: 1 kHz tick from the 10 MHz clock
  localparam int unsigned WDT_TICK_HZ       = 1000;
  localparam int unsigned WDT_TICK_CYC      = CLK_HZ / WDT_TICK_HZ;
  localparam int unsigned WDT_NUM_PER       = 11;

  // reset source bit positions
  localparam int unsigned SRC_POR  = 0;
  localparam int unsigned SRC_EXT  = 1;
  localparam int unsigned SRC_BRN  = 2;
  localparam int unsigned SRC_WDT  = 3;
  localparam int unsigned SRC_DBG  = 4;
  localparam int unsigned SRC_SW   = 5;
  localparam int unsigned NUM_SRC  = 6;

  // reset values
  localparam logic [15:0] RST_VEC_DEFAULT = 16'h0000;
  localparam logic [3:0]  WDT_PER_RESET   = 4'h0;
  localparam logic [3:0]  WDT_WIN_RESET   = 4'h0;

  // release sequence states
  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_DELAY = 3'b001,
    ST_OSC   = 3'b010,
    ST_CAL   = 3'b011,
    ST_RUN   = 3'b100
  } seq_state_t;

  // timeout period in 1 kHz ticks: 8 ms doubling up to 8 s
  function automatic logic [13:0] wdt_ticks(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > 4'ha) ? 4'ha : sel;
    wdt_ticks = 14'(14'h0008 << s);
  endfunction

endpackage

// [logic/watchdog_timer.sv]
// watchdog timer with normal and window modes
`timescale 1ns/100ps
module watchdog_timer
  import rst_wdt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // 1 kHz tick and configuration
  input  wire logic        tick_i,
  input  wire logic        enable_i,
  input  wire logic        window_en_i,
  input  wire logic [3:0]  period_i,
  input  wire logic [3:0]  window_i,
  input  wire logic        restart_i,
  // reset request pulse
  output logic             wdt_rst_o
);

  logic [13:0] count_r;
  logic [13:0] count_nxt;
  logic [$clog2(WDT_RST_CYC+1)-1:0] pulse_r;
  logic        expired;
  logic        early;
  logic        fire;
  logic        win_open;

  // window is closed until the window period has elapsed
  assign win_open  = count_r >= wdt_ticks(window_i);
  assign expired   = enable_i && tick_i &&
                     (count_r + 14'h0001 >= wdt_ticks(period_i));
  assign early     = enable_i && window_en_i && restart_i &&
                     !win_open;
  assign fire      = expired || early;
  assign count_nxt = (!enable_i || restart_i || fire) ? 14'h0000 :
                     tick_i ? count_r + 14'h0001 : count_r;

  // count of 1 kHz ticks since last restart
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_r <= 14'h0000;
    else
      count_r <= count_nxt;
  end

  // stretch request to one 2 MHz period
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pulse_r <= '0;
    else if (fire)
      pulse_r <= ($clog2(WDT_RST_CYC+1))'(WDT_RST_CYC);
    else if (pulse_r != '0)
      pulse_r <= pulse_r - 1'b1;
  end

  assign wdt_rst_o = (pulse_r != '0);

endmodule // watchdog_timer

// [logic/reset_and_watchdog_control.sv]
// reset controller with sources, release sequence and watchdog
`timescale 1ns/100ps
module reset_and_watchdog_control
  import rst_wdt_pkg::*;
#(
  parameter logic [15:0] BOOT_START = 16'h4000
)
(
  // clock and power-on reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // analog reset sources
  input  wire logic                power_on_threshold_low_i,
  input  wire logic                brownout_detect_i,
  input  wire logic                brownout_detect_enable_i,
  input  wire logic                chip_erase_i,
  input  wire logic                ext_reset_n_i,
  // debug programming port
  input  wire logic                debug_programming_port_en_i,
  input  wire logic                debug_programming_port_rst_i,
  // software control
  input  wire logic                sw_reset_wr_i,
  input  wire logic [NUM_SRC-1:0]  status_clr_i,
  input  wire logic                boot_reloc_i,
  // watchdog configuration
  input  wire logic                watchdog_restart_instruction_i,
  input  wire logic                wdt_unlock_i,
  input  wire logic                wdt_cfg_wr_i,
  input  wire logic                wdt_enable_i,
  input  wire logic                wdt_window_en_i,
  input  wire logic [3:0]          wdt_period_i,
  input  wire logic [3:0]          wdt_window_i,
  input  wire logic                wdt_lock_fuse_i,
  // outputs
  output logic                     sys_rst_n_o,
  output logic                     pins_hiz_o,
  output logic [15:0]              reset_vector_o,
  output logic [NUM_SRC-1:0]       reset_status_o,
  output logic                     rc2m_select_o,
  output logic                     other_clocks_off_o,
  output logic                     brownout_force_o,
  output logic                     wdt_enabled_o,
  output logic [1:0]               seq_stage_o
);

  // -------------------------------------------------------------
  // reset synchroniser
  // -------------------------------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;

  // two-flop release of the power-on reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // -------------------------------------------------------------
  // reset sources
  // -------------------------------------------------------------
  logic [$clog2(MIN_EXT_CYC+1)-1:0] ext_cnt_r;
  logic                             ext_req_r;
  logic [1:0]                       sw_cnt_r;
  logic                             sw_req_r;
  logic                             wdt_req;
  logic                             brn_active;
  logic                             brn_req;
  logic [NUM_SRC-1:0]               src_req;
  logic                             any_req;

  // brownout forced on when disabled but erase or debug active
  assign brn_active = brownout_detect_enable_i || chip_erase_i ||
                      debug_programming_port_en_i;
  assign brn_req    = brn_active && brownout_detect_i;

  // external pin must stay low for the minimum pulse
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      ext_cnt_r <= '0;
      ext_req_r <= 1'b0;
    end
    else if (ext_reset_n_i)
    begin
      ext_cnt_r <= '0;
      ext_req_r <= 1'b0;
    end
    else if (ext_cnt_r ==
             ($clog2(MIN_EXT_CYC+1))'(MIN_EXT_CYC - 1))
      ext_req_r <= 1'b1;
    else
      ext_cnt_r <= ext_cnt_r + 1'b1;
  end

  // software request stands a fixed time, then drops so release can start
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      sw_cnt_r <= 2'h0;
      sw_req_r <= 1'b0;
    end
    else if (sw_req_r)
    begin
      if (sw_cnt_r == 2'(SW_RST_CYC - 1))
        sw_req_r <= 1'b0;
      sw_cnt_r <= sw_cnt_r + 2'h1;
    end
    else if (sw_reset_wr_i)
    begin
      sw_cnt_r <= 2'h0;
      sw_req_r <= 1'b1;
    end
  end

  assign src_req[SRC_POR] = power_on_threshold_low_i;
  assign src_req[SRC_EXT] = ext_req_r;
  assign src_req[SRC_BRN] = brn_req;
  assign src_req[SRC_WDT] = wdt_req;
  assign src_req[SRC_DBG] = debug_programming_port_rst_i;
  assign src_req[SRC_SW]  = sw_req_r;
  assign any_req          = |src_req;

  // -------------------------------------------------------------
  // asynchronous reset assertion
  // -------------------------------------------------------------
  logic req_s1_r;
  logic req_s2_r;
  logic core_rst_n;

  // any request forces the release logic asynchronously
  assign core_rst_n = rst_s2_r && !any_req;

  // synchronise the release of the combined request
  always_ff @(posedge clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end
    else
    begin
      req_s1_r <= 1'b1;
      req_s2_r <= req_s1_r;
    end
  end

  // -------------------------------------------------------------
  // release sequence
  // -------------------------------------------------------------
  seq_state_t  state_r;
  seq_state_t  state_nxt;
  logic [7:0]  stage_cnt_r;
  logic        stage_done;
  logic [7:0]  stage_len;

  assign stage_len  = (state_r == ST_DELAY) ? 8'(RST_DELAY_CYC) :
                      (state_r == ST_OSC)   ? 8'(OSC_START_CYC) :
                                              8'(OSC_CAL_CYC);
  assign stage_done = (stage_cnt_r == stage_len - 8'h01);

  // next stage of the release
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD:  state_nxt = req_s2_r ? ST_DELAY : ST_HOLD;
      ST_DELAY: state_nxt = stage_done ? ST_OSC : ST_DELAY;
      ST_OSC:   state_nxt = stage_done ? ST_CAL : ST_OSC;
      ST_CAL:   state_nxt = stage_done ? ST_RUN : ST_CAL;
      ST_RUN:   state_nxt = ST_RUN;
      default:  state_nxt = ST_HOLD;
    endcase
  end

  // state held in hold while any request is active
  always_ff @(posedge clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
      state_r <= ST_HOLD;
    else
      state_r <= state_nxt;
  end

  // stage cycle counter
  always_ff @(posedge clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
      stage_cnt_r <= 8'h00;
    else if (state_r != state_nxt)
      stage_cnt_r <= 8'h00;
    else if (state_r != ST_RUN && state_r != ST_HOLD)
      stage_cnt_r <= stage_cnt_r + 8'h01;
  end

  // -------------------------------------------------------------
  // outputs of the sequencer
  // -------------------------------------------------------------
  logic running;
  assign running = (state_r == ST_RUN);

  // outputs from flops, loaded asynchronously with reset values (pins_hiz_o, rc2m_select_o, other_clocks_off_o to 1)
  always_ff @(posedge clk_i or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      sys_rst_n_o        <= 1'b0;
      pins_hiz_o         <= 1'b1;
      rc2m_select_o      <= 1'b1;
      other_clocks_off_o <= 1'b1;
      seq_stage_o        <= 2'h0;
    end
    else
    begin
      sys_rst_n_o        <= running;
      pins_hiz_o         <= !running;
      rc2m_select_o      <= 1'b1;
      other_clocks_off_o <= 1'b1;
      seq_stage_o        <= state_r[1:0];
    end
  end

  // vector chosen while in reset
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      reset_vector_o <= RST_VEC_DEFAULT;
    else if (!running)
      reset_vector_o <= boot_reloc_i ? BOOT_START
                                     : RST_VEC_DEFAULT;
  end

  // brownout force indication
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      brownout_force_o <= 1'b0;
    else
      brownout_force_o <= !brownout_detect_enable_i && brn_active;
  end

  // -------------------------------------------------------------
  // reset status flags
  // -------------------------------------------------------------
  logic [NUM_SRC-1:0] status_nxt;
  logic [NUM_SRC-1:0] src_hit;

  assign src_hit    = src_req | {{(NUM_SRC-1){1'b0}}, !rst_s2_r};
  assign status_nxt = (reset_status_o & ~status_clr_i) |
                      src_hit;

  // only power-on reset or status_clr_i clears the flags
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reset_status_o <= 6'h01;
    else
      reset_status_o <= status_nxt;
  end

  // -------------------------------------------------------------
  // protected watchdog configuration
  // -------------------------------------------------------------
  logic       cfg_en_r;
  logic       cfg_win_r;
  logic [3:0] cfg_per_r;
  logic [3:0] cfg_wsel_r;
  logic       cfg_ok;

  assign cfg_ok = wdt_cfg_wr_i && wdt_unlock_i && !wdt_lock_fuse_i;

  // settings load only through unlock, never under fuse lock
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      cfg_en_r   <= 1'b0;
      cfg_win_r  <= 1'b0;
      cfg_per_r  <= WDT_PER_RESET;
      cfg_wsel_r <= WDT_WIN_RESET;
    end
    else if (cfg_ok)
    begin
      cfg_en_r   <= wdt_enable_i;
      cfg_win_r  <= wdt_window_en_i;
      cfg_per_r  <= wdt_period_i;
      cfg_wsel_r <= wdt_window_i;
    end
  end

  // enabled flag mirror
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      wdt_enabled_o <= 1'b0;
    else
      wdt_enabled_o <= cfg_en_r;
  end

  // -------------------------------------------------------------
  // 1 kHz tick divider and watchdog
  // -------------------------------------------------------------
  logic [$clog2(WDT_TICK_CYC)-1:0] div_r;
  logic                            tick;

  assign tick = (div_r == ($clog2(WDT_TICK_CYC))'(WDT_TICK_CYC - 1));

  // free-running divider, unaffected by sleep
  always_ff @(posedge clk_i or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
      div_r <= '0;
    else
      div_r <= tick ? '0 : div_r + 1'b1;
  end

  watchdog_timer u_wdt (
    .clk_i       (clk_i),
    .rst_n_i     (rst_s2_r),
    .tick_i      (tick),
    .enable_i    (cfg_en_r),
    .window_en_i (cfg_win_r),
    .period_i    (cfg_per_r),
    .window_i    (cfg_wsel_r),
    .restart_i   (watchdog_restart_instruction_i && running),
    .wdt_rst_o   (wdt_req)
  );

endmodule // reset_and_watchdog_control

// [verif/reset_ctl_properties.sv]
// assertions on the reset and watchdog controller ports
`timescale 1ns/100ps
module reset_ctl_properties
  import rst_wdt_pkg::*;
#(
  parameter logic [15:0] BOOT_START = 16'h4000
)
(
  // clock, reset and inputs
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               power_on_threshold_low_i,
  input wire logic               brownout_detect_i,
  input wire logic               brownout_detect_enable_i,
  input wire logic               chip_erase_i,
  input wire logic               ext_reset_n_i,
  input wire logic               debug_programming_port_en_i,
  input wire logic               debug_programming_port_rst_i,
  input wire logic               sw_reset_wr_i,
  input wire logic [NUM_SRC-1:0] status_clr_i,
  input wire logic               boot_reloc_i,
  input wire logic               wdt_unlock_i,
  input wire logic               wdt_cfg_wr_i,
  input wire logic               wdt_lock_fuse_i,
  // outputs
  input wire logic               sys_rst_n_o,
  input wire logic               pins_hiz_o,
  input wire logic [15:0]        reset_vector_o,
  input wire logic [NUM_SRC-1:0] reset_status_o,
  input wire logic               rc2m_select_o,
  input wire logic               other_clocks_off_o,
  input wire logic               brownout_force_o,
  input wire logic               wdt_enabled_o
);
  // --------------------------------------------------
  // helper counters
  // --------------------------------------------------
  logic       req_w;
  logic [7:0] quiet_r;
  logic [7:0] quiet_nxt;
  logic [7:0] ext_lo_r;
  logic [7:0] ext_lo_nxt;

  // quiet counts low cycles with no request visible
  assign req_w = power_on_threshold_low_i | brownout_detect_i |
                 !ext_reset_n_i | debug_programming_port_rst_i |
                 sw_reset_wr_i;
  assign quiet_nxt = (req_w | sys_rst_n_o) ? 8'h00 :
                     quiet_r + {7'h00, quiet_r != 8'hff};
  assign ext_lo_nxt = ext_reset_n_i ? 8'h00 :
                      ext_lo_r + {7'h00, ext_lo_r != 8'hff};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      quiet_r  <= 8'h00;
      ext_lo_r <= 8'h00;
    end
    else
    begin
      quiet_r  <= quiet_nxt;
      ext_lo_r <= ext_lo_nxt;
    end
  end

  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  req_hold_a: assert property (
    debug_programming_port_rst_i |-> !sys_rst_n_o)
    else $error("no reset during request");
  hiz_a: assert property (!sys_rst_n_o |-> pins_hiz_o)
    else $error("pins driven in reset");
  release_min_a: assert property (
    $rose(sys_rst_n_o) |-> quiet_r >= 8'd112)
    else $error("release too early");
  release_max_a: assert property (quiet_r <= 8'd128)
    else $error("release too late");
  sw_reset_a: assert property (
    sw_reset_wr_i && sys_rst_n_o |-> ##[1:2] !sys_rst_n_o)
    else $error("software reset late");
  ext_filter_a: assert property (
    $rose(reset_status_o[SRC_EXT]) |-> ext_lo_r >= 8'd10)
    else $error("short pin pulse accepted");
  ext_held_a: assert property (ext_lo_r >= 8'd16 |-> !sys_rst_n_o)
    else $error("reset lost with pin low");
  status_sticky_a: assert property (
    !power_on_threshold_low_i && !$past(power_on_threshold_low_i) |->
    ($past(reset_status_o) & ~$past(status_clr_i) & ~reset_status_o)
    == '0)
    else $error("status flag lost");
  vector_sel_a: assert property ($rose(sys_rst_n_o) |->
    reset_vector_o == ($past(boot_reloc_i) ? BOOT_START : 16'h0000))
    else $error("wrong reset vector");
  clocks_default_a: assert property ($rose(sys_rst_n_o) |->
    rc2m_select_o && other_clocks_off_o)
    else $error("clock defaults wrong");
  bod_force_a: assert property (!brownout_detect_enable_i &&
    (chip_erase_i || debug_programming_port_en_i) |->
    ##[1:2] brownout_force_o)
    else $error("brownout not forced");
  cfg_refused_a: assert property (wdt_cfg_wr_i && sys_rst_n_o &&
    (!wdt_unlock_i || wdt_lock_fuse_i) |-> ##2 $stable(wdt_enabled_o))
    else $error("locked config changed");

  cover property ($rose(reset_status_o[SRC_SW]));
  cover property ($rose(sys_rst_n_o) && boot_reloc_i);
  cover property (wdt_cfg_wr_i && wdt_unlock_i && !wdt_lock_fuse_i);
endmodule // reset_ctl_properties

bind reset_and_watchdog_control reset_ctl_properties #(
  .BOOT_START(BOOT_START)
) u_reset_ctl_properties (
  .clk_i, .rst_n_i, .power_on_threshold_low_i, .brownout_detect_i,
  .brownout_detect_enable_i, .chip_erase_i, .ext_reset_n_i,
  .debug_programming_port_en_i, .debug_programming_port_rst_i,
  .sw_reset_wr_i, .status_clr_i, .boot_reloc_i, .wdt_unlock_i,
  .wdt_cfg_wr_i, .wdt_lock_fuse_i, .sys_rst_n_o, .pins_hiz_o,
  .reset_vector_o, .reset_status_o, .rc2m_select_o,
  .other_clocks_off_o, .brownout_force_o, .wdt_enabled_o
);

// [verif/reset_sources_model.sv]
// supply monitors, reset pin and debug port in front of the block
`timescale 1ns/100ps
module reset_sources_model #(
  parameter int POR_RISE_MV = 1500,
  parameter int POR_FALL_MV = 1600,
  parameter int BOD_MV      = 1800
)
(
  // commands from the bench
  input  wire logic        clk_i,
  input  wire logic [11:0] supply_mv_i,
  input  wire logic        pin_low_i,
  input  wire logic        dbg_en_i,
  input  wire logic        dbg_rst_i,
  // lines into the block
  output logic             por_low_o = 1'b1,
  output logic             brownout_o = 1'b1,
  output logic             ext_reset_n_o = 1'b1,
  output logic             dbg_en_o = 1'b0,
  output logic             dbg_rst_o = 1'b0
);
  // falling threshold sits above the rising one
  always @(posedge clk_i)
  begin
    por_low_o <= supply_mv_i < (por_low_o ? POR_RISE_MV : POR_FALL_MV);
    brownout_o <= supply_mv_i < BOD_MV;
    ext_reset_n_o <= !pin_low_i;
    dbg_en_o <= dbg_en_i;
    dbg_rst_o <= dbg_rst_i && dbg_en_i;
  end
endmodule // reset_sources_model

// [verif/test_reset_and_watchdog_control.sv]
// self-checking bench for the reset and watchdog controller
`timescale 1ns/100ps
module test_reset_and_watchdog_control
  import rst_wdt_pkg::*;
;
  localparam logic [15:0] BOOT = 16'h4000;
  // stimulus lines that drive() can set
  typedef enum logic [2:0] {
    S_PIN, S_SW, S_DBG_EN, S_DBG_RST, S_ERASE, S_RESTART, S_RST, S_RELOC
  } drv_t;
  logic clk_i, rst_n_i, pin_low, dbg_en, dbg_rst, win;
  logic [1:0] stage;
  logic por_low, brownout_detect, ext_n, dbg_en_w, dbg_rst_w;
  logic bod_en, erase, sw_wr, reloc, watchdog_restart_instruction, unlock, cfg_wr, wen, fuse;
  logic sys_n, hiz, rc2m, clk_off, force_o, wdt_on;
  logic [11:0] supply;
  logic [NUM_SRC-1:0] clr, stat;
  logic [15:0] vec;
  int bad_count, n_checks;

  reset_sources_model u_reset_sources_model (.clk_i(clk_i),
    .supply_mv_i(supply), .pin_low_i(pin_low), .dbg_en_i(dbg_en),
    .dbg_rst_i(dbg_rst), .por_low_o(por_low), .brownout_o(brownout_detect),
    .ext_reset_n_o(ext_n), .dbg_en_o(dbg_en_w), .dbg_rst_o(dbg_rst_w));

  reset_and_watchdog_control #(.BOOT_START(BOOT))
  u_reset_and_watchdog_control (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .power_on_threshold_low_i(por_low), .brownout_detect_i(brownout_detect),
    .brownout_detect_enable_i(bod_en), .chip_erase_i(erase),
    .ext_reset_n_i(ext_n), .debug_programming_port_en_i(dbg_en_w),
    .debug_programming_port_rst_i(dbg_rst_w), .sw_reset_wr_i(sw_wr),
    .status_clr_i(clr), .boot_reloc_i(reloc),
    .watchdog_restart_instruction_i(watchdog_restart_instruction), .wdt_unlock_i(unlock),
    .wdt_cfg_wr_i(cfg_wr), .wdt_enable_i(wen), .wdt_window_en_i(win),
    .wdt_period_i(4'ha), .wdt_window_i(4'h0), .wdt_lock_fuse_i(fuse),
    .sys_rst_n_o(sys_n), .pins_hiz_o(hiz), .reset_vector_o(vec),
    .reset_status_o(stat), .rc2m_select_o(rc2m),
    .other_clocks_off_o(clk_off), .brownout_force_o(force_o),
    .wdt_enabled_o(wdt_on), .seq_stage_o(stage));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  // wait for release and judge its length
  task automatic up(input int lo);
    int n;
    n = 0;
    while (sys_n !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
    chk(16'(n >= lo && n <= 130), 16'h1);
  endtask

  // one stimulus line set at a rising edge, then n edges waited
  task automatic drive(input drv_t sel, input logic v, input int n);
    @(posedge clk_i);
    case (sel)
      S_PIN:     pin_low <= v;
      S_SW:      sw_wr   <= v;
      S_DBG_EN:  dbg_en  <= v;
      S_DBG_RST: dbg_rst <= v;
      S_ERASE:   erase   <= v;
      S_RESTART: watchdog_restart_instruction     <= v;
      S_RST:     rst_n_i <= v;
      default:   reloc   <= v;
    endcase
    cyc(n);
    #1;
  endtask

  // supply level set at a rising edge, then n edges waited
  task automatic set_supply(input logic [11:0] v, input int n);
    @(posedge clk_i);
    supply <= v;
    cyc(n);
    #1;
  endtask

  task automatic wcfg(input logic u, f, e, x);
    @(posedge clk_i);
    {unlock, fuse, wen, cfg_wr} <= {u, f, e, 1'b1};
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    cyc(1);
    #1;
    chk(16'(wdt_on), 16'(x));
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // power-on values and first release
  task automatic t_por();
    #1;
    chk({hiz, 3'h0, stat, vec[5:0]}, 16'h8040);
    chk(16'(sys_n), 16'h0);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    up(112);
    chk({hiz, rc2m, clk_off, stat}, 16'h00c1);
  endtask

  // short pin pulse ignored, long one held
  task automatic min_external_pulse();
    drive(S_PIN, 1'b1, 5);
    drive(S_PIN, 1'b0, 6);
    chk(16'(sys_n), 16'h1);
    drive(S_PIN, 1'b1, 20);
    chk(16'(sys_n), 16'h0);
    drive(S_PIN, 1'b0, 0);
    up(112);
    chk(16'(stat), 16'h03);
  endtask

  // software reset with relocated vector, then clear its flag
  task automatic t_sw();
    reloc <= 1'b1;
    drive(S_SW, 1'b1, 0);
    drive(S_SW, 1'b0, 2);
    chk(16'(sys_n), 16'h0);
    up(112);
    chk(vec, BOOT);
    chk(16'(stat), 16'h23);
    @(posedge clk_i);
    clr <= 6'h20;
    @(posedge clk_i);
    clr <= 6'h00;
    cyc(1);
    #1;
    chk(16'(stat), 16'h03);
    drive(S_RELOC, 1'b0, 0);
  endtask

  // debug port reset, restarted mid sequence
  task automatic t_dbg();
    drive(S_DBG_EN, 1'b1, 3);
    chk({force_o, sys_n}, 16'h3);
    drive(S_DBG_RST, 1'b1, 1);
    chk(16'(sys_n), 16'h0);
    drive(S_DBG_RST, 1'b0, 60);
    chk(16'({stage, sys_n}), 16'h2);
    drive(S_DBG_RST, 1'b1, 1);
    drive(S_DBG_RST, 1'b0, 0);
    up(112);
    chk(16'(stat), 16'h13);
    drive(S_DBG_EN, 1'b0, 0);
  endtask

  // forced brownout, brownout reset and power dip
  task automatic t_bod();
    drive(S_ERASE, 1'b1, 3);
    chk(16'(force_o), 16'h1);
    drive(S_ERASE, 1'b0, 3);
    chk(16'(force_o), 16'h0);
    bod_en <= 1'b1;
    set_supply(12'd1700, 4);
    chk(16'(sys_n), 16'h0);
    set_supply(12'd3300, 0);
    up(112);
    chk(16'(stat), 16'h17);
    bod_en <= 1'b0;
    set_supply(12'd1550, 4);
    chk(16'(sys_n), 16'h0);
    set_supply(12'd3300, 0);
    up(112);
  endtask

  // watchdog configuration protection and early restart in window mode
  task automatic t_wdt();
    wcfg(1'b0, 1'b0, 1'b1, 1'b0);
    wcfg(1'b1, 1'b1, 1'b1, 1'b0);
    wcfg(1'b1, 1'b0, 1'b1, 1'b1);
    drive(S_RESTART, 1'b1, 0);
    drive(S_RESTART, 1'b0, 4);
    chk(16'(sys_n), 16'h1);
    win <= 1'b1;
    wcfg(1'b1, 1'b0, 1'b1, 1'b1);
    drive(S_RESTART, 1'b1, 0);
    drive(S_RESTART, 1'b0, 4);
    chk(16'(sys_n), 16'h0);
    up(112);
    chk(16'(stat), 16'h1f);
    wcfg(1'b1, 1'b0, 1'b0, 1'b0);
    drive(S_RST, 1'b0, 8);
    chk(16'(stat), 16'h01);
    drive(S_RST, 1'b1, 0);
    up(112);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    {rst_n_i, pin_low, dbg_en, dbg_rst, bod_en, erase, sw_wr} = '0;
    {reloc, watchdog_restart_instruction, unlock, cfg_wr, wen, fuse, win} = '0;
    clr = '0;
    supply = 12'd0;
    bad_count = 0;
    n_checks = 0;
    cyc(2);
    supply <= 12'd3300;
    cyc(6);
    t_por();
    min_external_pulse();
    t_sw();
    t_dbg();
    t_bod();
    t_wdt();
    complete_run();
  end

  // hang guard
  initial
  begin
    #(3000 * 100);
    bad_count++;
    complete_run();
  end
endmodule // test_reset_and_watchdog_control
